//--- rcp_pkg.sv
// Notes on behaviour
// - Exactly one residual source is used, picked statically from coarse, sensitive or calculated, coarse by default.
// - Measured inputs compare fundamental RMS, true RMS or peak-to-peak as chosen (RMS default), the calculated source always its fundamental.
// - The true RMS value is built from all 32 harmonic components, not the fundamental alone.
// - Every selectable measurement value is taken up for comparison on a 5 ms time base.
// - Pick-up is raised when the selected magnitude exceeds the level, and the magnitude to level ratio is computed all the time.
// - Once picked up, the stage releases only below 97 percent of the configured level.
// - The level runs from 0.0001 to 40.00 times nominal in steps of 0.0001, default 1.20.
// - Level writes from the supervisory bus are taken only while remote setting is allowed, which is off by default.
// - A forced status of normal, start, trip or blocked, default normal, acts only while global forcing is enabled.
// - Source, magnitude, remote control and forced status are static and ignore setting group changes.
// - A change of active setting group brings its level into use while running, with no restart.
// - One level serves every evaluated quantity, with no per-phase thresholds.
// - Block is sampled at the start of each cycle; pick-up without block raises start, with block raises blocked only.
// - Block arriving after start clears start as though pick-up had dropped.
package rcp_pkg;

    // Magnitudes are unsigned counts of 0.0001 x nominal current.
    localparam int MAG_W = 24;
    localparam int LVL_W = 20;
    localparam logic [LVL_W-1:0] LEVEL_MIN = 20'h00001;
    localparam logic [LVL_W-1:0] LEVEL_MAX = 20'h61A80;
    localparam logic [LVL_W-1:0] LEVEL_DEF = 20'h02EE0;
    localparam int RESET_PCT = 97;
    localparam int FULL_PCT = 100;
    localparam int HARM_N = 32;
    localparam int GROUPS = 8;

    // Timing: the evaluation tick.
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_NS = 5000000;
    localparam int TICK_CYC = TICK_NS / CLK_PERIOD_NS;

    // Register byte offsets.
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_RATIO = 8'h08;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h0C;
    localparam logic [7:0] OFS_IRQ_EN = 8'h10;
    localparam logic [7:0] OFS_IRQ_CLR = 8'h14;
    localparam logic [7:0] OFS_MEAS = 8'h18;
    localparam logic [7:0] OFS_LEVEL0 = 8'h20;

    // Control field positions.
    localparam int CTRL_SRC_LSB = 0;
    localparam int CTRL_MAG_LSB = 2;
    localparam int CTRL_REMOTE_BIT = 4;
    localparam int CTRL_FORCE_LSB = 5;
    localparam logic [31:0] CTRL_RST = 32'h00000000;

    // Interrupt event bits.
    localparam int EV_START_ON = 0;
    localparam int EV_START_OFF = 1;
    localparam int EV_BLOCK_ON = 2;
    localparam int EV_N = 3;

    // Ratio is in 0.01 steps and saturates at 1250.00.
    localparam logic [31:0] RATIO_MAX = 32'h0001E848;

    typedef enum logic [1:0] { SRC_COARSE, SRC_SENSITIVE, SRC_CALC, SRC_RSVD } rcp_src_t;
    typedef enum logic [1:0] { MAG_RMS, MAG_TRMS, MAG_PP, MAG_RSVD } rcp_mag_t;
    typedef enum logic [1:0] { ST_NORMAL, ST_START, ST_TRIP, ST_BLOCKED } rcp_cond_t;
    typedef enum { S_IDLE, S_ROOT, S_DIV, S_EVAL } rcp_state_t;

    // Front-end magnitudes, refreshed by the measurement path.
    typedef struct packed {
        logic [LVL_W-1:0] coarse_rms;
        logic [LVL_W-1:0] coarse_pp;
        logic [LVL_W-1:0] sens_rms;
        logic [LVL_W-1:0] sens_pp;
        logic [LVL_W-1:0] calc_fund;
    } rcp_meas_t;

    // One harmonic amplitude; channel 0 coarse, 1 sensitive.
    typedef struct packed {
        logic             valid;
        logic             chan;
        logic [4:0]       index;
        logic [LVL_W-1:0] amp;
    } rcp_harm_t;

endpackage : rcp_pkg

//--- rcp_stage.sv
`timescale 1ns/10ps
`default_nettype none
module rcp_stage #(
    parameter int TICK_CYCLES = rcp_pkg::TICK_CYC
) (
    // Clock and reset.
    input  wire logic              SYS_CLK,
    input  wire logic              RST_B,
    // APB register port.
    input  wire logic              PSEL,
    input  wire logic              PENABLE,
    input  wire logic              PWRITE,
    input  wire logic [7:0]        PADDR,
    input  wire logic [31:0]       PWDATA,
    output logic      [31:0]       PRDATA,
    output logic                   PREADY,
    output logic                   PSLVERR,
    // Measurement front end.
    input  wire rcp_pkg::rcp_meas_t MEAS,
    input  wire rcp_pkg::rcp_harm_t HARM,
    // System controls.
    input  wire logic [2:0]        ACTIVE_GROUP,
    input  wire logic              BLOCK_IN,
    input  wire logic              FORCE_ENA,
    // Stage outputs.
    output logic                   START,
    output logic                   BLOCKED,
    output logic                   TRIP,
    output logic                   IRQ
);
    // The evaluation ends at most 57 clocks after the tick; tick periods below 200 clocks are rejected.
    if (TICK_CYCLES < 200) begin : g_tick_check
        $error("TICK_CYCLES too small for one evaluation");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations.
    localparam int SQ_W = 2 * rcp_pkg::LVL_W + 6;
    localparam int RT_W = SQ_W / 2;
    localparam int NUM_W = 32;

    logic [31:0]                ctrl_r;
    logic [rcp_pkg::LVL_W-1:0]  level_r [rcp_pkg::GROUPS];
    logic [rcp_pkg::EV_N-1:0]   irq_stat_r;
    logic [rcp_pkg::EV_N-1:0]   irq_en_r;
    logic [31:0]                ratio_r;
    logic [rcp_pkg::MAG_W-1:0]  mag_r;
    logic [rcp_pkg::LVL_W-1:0]  lvl_r;
    logic                       blk_r;
    logic                       picked_r;
    logic                       tick_r;
    logic [31:0]                tick_cnt_r;
    logic [SQ_W-1:0]            acc_r;
    logic [SQ_W-1:0]            trms_sq_r;
    logic [RT_W-1:0]            root_r;
    logic [5:0]                 step_r;
    logic [NUM_W-1:0]           num_r;
    logic [NUM_W-1:0]           quo_r;
    logic [NUM_W:0]             rem_r;
    rcp_pkg::rcp_state_t        state_r;
    rcp_pkg::rcp_src_t          src;
    rcp_pkg::rcp_mag_t          msel;
    rcp_pkg::rcp_cond_t         force_sel;
    logic                       remote_ok;
    logic                       wr_en;
    logic                       lvl_hit;
    logic [2:0]                 lvl_idx;
    logic [rcp_pkg::MAG_W-1:0]  direct_mag;
    logic                       forced;
    logic                       pick_nxt;
    logic [RT_W-1:0]            root_try;

    // Hysteresis test: is a magnitude below pct percent of the level?
    function automatic logic below_pct(input logic [rcp_pkg::MAG_W-1:0] m,
                                       input logic [rcp_pkg::LVL_W-1:0] l,
                                       input int unsigned pct);
        logic [39:0] lhs;
        logic [39:0] rhs;
        lhs = 40'(m) * 40'(rcp_pkg::FULL_PCT);
        rhs = 40'(l) * 40'(pct);
        return lhs < rhs;
    endfunction : below_pct

    // Square of one harmonic amplitude, widened before the product so no bit is lost.
    function automatic logic [SQ_W-1:0] amp_sq(input logic [rcp_pkg::LVL_W-1:0] a);
        return SQ_W'(a) * SQ_W'(a);
    endfunction : amp_sq

    // Decoded static settings.
    assign src       = rcp_pkg::rcp_src_t'(ctrl_r[rcp_pkg::CTRL_SRC_LSB +: 2]);
    assign msel      = rcp_pkg::rcp_mag_t'(ctrl_r[rcp_pkg::CTRL_MAG_LSB +: 2]);
    assign force_sel = rcp_pkg::rcp_cond_t'(ctrl_r[rcp_pkg::CTRL_FORCE_LSB +: 2]);
    assign remote_ok = ctrl_r[rcp_pkg::CTRL_REMOTE_BIT];
    assign forced    = FORCE_ENA && (force_sel != rcp_pkg::ST_NORMAL);

    ////////////////////////////////////////////////////////////////////////////////
    // APB slave, one wait state: PREADY rises in the second access cycle.
    assign wr_en   = PSEL && PENABLE && PREADY && PWRITE;
    assign lvl_hit = (PADDR >= rcp_pkg::OFS_LEVEL0) && (PADDR[1:0] == 2'h0)
                     && (PADDR < 8'(rcp_pkg::OFS_LEVEL0 + 4 * rcp_pkg::GROUPS));
    assign lvl_idx = 3'((PADDR - rcp_pkg::OFS_LEVEL0) >> 2);

    // Ready, error and read data are all registered so the bus sees clean flops.
    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA  <= 32'h00000000;
        end else begin
            PREADY  <= PSEL && PENABLE && !PREADY;
            PSLVERR <= 1'b0;
            if (PSEL && PENABLE && !PREADY) begin
                PRDATA <= 32'h00000000;
                if (lvl_hit) begin
                    if (!PWRITE) PRDATA <= 32'(level_r[lvl_idx]);
                end else begin
                    case (PADDR)
                        rcp_pkg::OFS_CTRL:     PRDATA <= ctrl_r;
                        rcp_pkg::OFS_STATUS:   PRDATA <= {28'h0000000, picked_r, blk_r,
                                                          BLOCKED, START};
                        rcp_pkg::OFS_RATIO:    PRDATA <= ratio_r;
                        rcp_pkg::OFS_IRQ_STAT: PRDATA <= 32'(irq_stat_r);
                        rcp_pkg::OFS_IRQ_EN:   PRDATA <= 32'(irq_en_r);
                        rcp_pkg::OFS_IRQ_CLR:  PRDATA <= 32'h00000000;
                        rcp_pkg::OFS_MEAS:     PRDATA <= 32'(mag_r);
                        default:               PSLVERR <= 1'b1;
                    endcase
                end
            end
        end
    end

    // Static settings live apart from the group levels, so a group switch never touches them.
    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            ctrl_r   <= rcp_pkg::CTRL_RST;
            irq_en_r <= '0;
        end else if (wr_en && PADDR == rcp_pkg::OFS_CTRL) begin
            ctrl_r <= {25'h0, PWDATA[6:0]};
        end else if (wr_en && PADDR == rcp_pkg::OFS_IRQ_EN) begin
            irq_en_r <= PWDATA[rcp_pkg::EV_N-1:0];
        end
    end

    // Group levels; bus writes need remote control allowed and an in-range value.
    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            for (int g = 0; g < rcp_pkg::GROUPS; g++) begin
                level_r[g] <= rcp_pkg::LEVEL_DEF;
            end
        end else if (wr_en && lvl_hit && remote_ok
                     && PWDATA[31:rcp_pkg::LVL_W] == '0
                     && PWDATA[rcp_pkg::LVL_W-1:0] >= rcp_pkg::LEVEL_MIN
                     && PWDATA[rcp_pkg::LVL_W-1:0] <= rcp_pkg::LEVEL_MAX) begin
            level_r[lvl_idx] <= PWDATA[rcp_pkg::LVL_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Tick divider: one-cycle pulse every 5 ms.
    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            tick_cnt_r <= 32'h00000000;
            tick_r     <= 1'b0;
        end else begin
            tick_r     <= (tick_cnt_r == 32'(TICK_CYCLES - 1));
            tick_cnt_r <= (tick_cnt_r == 32'(TICK_CYCLES - 1)) ? 32'h00000000
                                                                 : tick_cnt_r + 32'h00000001;
        end
    end

    // True RMS: sum of squares over all harmonic slots of the selected channel.
    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            acc_r     <= '0;
            trms_sq_r <= '0;
        end else if (HARM.valid && HARM.chan == src[0] && src != rcp_pkg::SRC_CALC) begin
            acc_r <= (HARM.index == 5'h00) ? amp_sq(HARM.amp)
                                           : acc_r + amp_sq(HARM.amp);
            if (HARM.index == 5'(rcp_pkg::HARM_N - 1)) begin
                trms_sq_r <= acc_r + amp_sq(HARM.amp);
            end
        end
    end

    // Source and magnitude selection; the calculated input is always its fundamental.
    always_comb begin
        direct_mag = '0;
        case (src)
            rcp_pkg::SRC_SENSITIVE: direct_mag = rcp_pkg::MAG_W'(msel == rcp_pkg::MAG_PP ?
                                                 MEAS.sens_pp : MEAS.sens_rms);
            rcp_pkg::SRC_CALC:      direct_mag = rcp_pkg::MAG_W'(MEAS.calc_fund);
            default:                direct_mag = rcp_pkg::MAG_W'(msel == rcp_pkg::MAG_PP ?
                                                 MEAS.coarse_pp : MEAS.coarse_rms);
        endcase
    end

    assign root_try = root_r | (RT_W'(1) << step_r);
    assign pick_nxt = picked_r ? !below_pct(mag_r, lvl_r, rcp_pkg::RESET_PCT)
                               : (mag_r > rcp_pkg::MAG_W'(lvl_r));

    ////////////////////////////////////////////////////////////////////////////////
    // Per-tick sequencer: snapshot, optional square root, ratio divide, evaluate.
    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            state_r <= rcp_pkg::S_IDLE;
            mag_r   <= '0;
            lvl_r   <= rcp_pkg::LEVEL_DEF;
            blk_r   <= 1'b0;
            root_r  <= '0;
            step_r  <= 6'h00;
            num_r   <= '0;
            quo_r   <= '0;
            rem_r   <= '0;
        end else begin
            case (state_r)
                rcp_pkg::S_IDLE: begin
                    if (tick_r) begin
                        blk_r  <= BLOCK_IN;
                        lvl_r  <= level_r[ACTIVE_GROUP];
                        mag_r  <= direct_mag;
                        root_r <= '0;
                        // Step zero marks a fresh divide, so the root path also ends on it.
                        if (msel == rcp_pkg::MAG_TRMS && src != rcp_pkg::SRC_CALC) begin
                            step_r  <= 6'(RT_W - 1);
                            state_r <= rcp_pkg::S_ROOT;
                        end else begin
                            step_r  <= 6'h00;
                            state_r <= rcp_pkg::S_DIV;
                        end
                    end
                end
                rcp_pkg::S_ROOT: begin
                    if (SQ_W'(root_try) * SQ_W'(root_try) <= trms_sq_r) root_r <= root_try;
                    if (step_r == 6'h00) begin
                        mag_r   <= rcp_pkg::MAG_W'(root_r) | ((SQ_W'(root_try) * SQ_W'(root_try)
                                   <= trms_sq_r) ? rcp_pkg::MAG_W'(1) : '0);
                        state_r <= rcp_pkg::S_DIV;
                    end else begin
                        step_r <= step_r - 6'h01;
                    end
                end
                rcp_pkg::S_DIV: begin
                    // Restoring divide, one quotient bit per clock; only the step count marks
                    // the load cycle, since a zero magnitude would otherwise restart forever.
                    if (step_r == 6'h00) begin
                        num_r  <= NUM_W'(mag_r) * NUM_W'(rcp_pkg::FULL_PCT);
                        quo_r  <= '0;
                        rem_r  <= '0;
                        step_r <= 6'h3F;
                    end else begin
                        rem_r <= ({rem_r[NUM_W-1:0], num_r[NUM_W-1]} >= (NUM_W+1)'(lvl_r)) ?
                                 {rem_r[NUM_W-1:0], num_r[NUM_W-1]} - (NUM_W+1)'(lvl_r) :
                                 {rem_r[NUM_W-1:0], num_r[NUM_W-1]};
                        quo_r <= {quo_r[NUM_W-2:0], ({rem_r[NUM_W-1:0], num_r[NUM_W-1]}
                                  >= (NUM_W+1)'(lvl_r))};
                        num_r <= {num_r[NUM_W-2:0], 1'b0};
                        step_r <= step_r - 6'h01;
                        if (step_r == 6'(63 - NUM_W + 1)) state_r <= rcp_pkg::S_EVAL;
                    end
                end
                rcp_pkg::S_EVAL: begin
                    num_r   <= '0;
                    quo_r   <= '0;
                    rem_r   <= '0;
                    step_r  <= 6'h00;
                    state_r <= rcp_pkg::S_IDLE;
                end
                default: state_r <= rcp_pkg::S_IDLE;
            endcase
        end
    end

    // Evaluation: outputs move only in the evaluate cycle and hold until the next tick.
    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            picked_r <= 1'b0;
            ratio_r  <= 32'h00000000;
            START    <= 1'b0;
            BLOCKED  <= 1'b0;
            TRIP     <= 1'b0;
        end else if (state_r == rcp_pkg::S_EVAL) begin
            picked_r <= pick_nxt;
            ratio_r  <= (quo_r > rcp_pkg::RATIO_MAX) ? rcp_pkg::RATIO_MAX : quo_r;
            if (forced) begin
                START   <= force_sel == rcp_pkg::ST_START;
                TRIP    <= force_sel == rcp_pkg::ST_TRIP;
                BLOCKED <= force_sel == rcp_pkg::ST_BLOCKED;
            end else begin
                START   <= pick_nxt && !blk_r;
                BLOCKED <= pick_nxt && blk_r;
                TRIP    <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupts: sticky events, set wins over a clear in the same cycle.
    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            irq_stat_r <= '0;
            IRQ        <= 1'b0;
        end else begin
            irq_stat_r <= (irq_stat_r & ~((wr_en && PADDR == rcp_pkg::OFS_IRQ_CLR) ?
                          PWDATA[rcp_pkg::EV_N-1:0] : '0))
                          | {($rose(BLOCKED)), ($fell(START)), ($rose(START))};
            IRQ <= |(irq_stat_r & irq_en_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_B);

    sequence tick_seen;
        tick_r && state_r == rcp_pkg::S_IDLE;
    endsequence
    sequence eval_done;
        state_r == rcp_pkg::S_EVAL;
    endsequence

    a_eval_per_tick: assert property (tick_seen |-> ##[1:80] eval_done)
        else $error("Evaluation did not follow the tick in time.");
    a_outputs_hold: assert property (state_r != rcp_pkg::S_EVAL |=> $stable(START)
                                     && $stable(BLOCKED) && $stable(TRIP))
        else $error("Stage output moved outside an evaluation.");
    a_pickup_rise: assert property (eval_done and !picked_r
                                    && mag_r > rcp_pkg::MAG_W'(lvl_r) |=> picked_r)
        else $error("Pick-up missed above the level.");
    a_release_hyst: assert property (eval_done and picked_r
                                     && !below_pct(mag_r, lvl_r, rcp_pkg::RESET_PCT)
                                     |=> picked_r)
        else $error("Released above the reset ratio.");
    a_block_gates: assert property (eval_done and blk_r && !forced |=> !START)
        else $error("Start stayed high under block.");
    a_start_free: assert property (eval_done and !blk_r && !forced && pick_nxt
                                   |=> START && !BLOCKED)
        else $error("Start not raised on unblocked pick-up.");
    a_level_gate: assert property (wr_en && lvl_hit && !remote_ok
                                   |=> level_r[$past(lvl_idx)] == $past(level_r[lvl_idx]))
        else $error("Level changed with remote control disabled.");
    a_force_trip: assert property (eval_done and forced
                                   && force_sel == rcp_pkg::ST_TRIP |=> TRIP && !START)
        else $error("Forced trip not shown.");
    a_static_group: assert property ($changed(ACTIVE_GROUP) && !wr_en |=> $stable(ctrl_r))
        else $error("Static settings moved on a group change.");
    a_irq_follow: assert property (|(irq_stat_r & irq_en_r) |=> IRQ)
        else $error("Interrupt not raised for an enabled event.");

endmodule : rcp_stage
`default_nettype wire

//--- rcp_fe_model.sv
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Front-end stand-in: refreshes magnitudes and streams 32 harmonic slots on channel 0.
module rcp_fe_model (
    // Clock and reset.
    input  wire logic               sys_clk,
    input  wire logic               rst_b,
    // Values the bench wants reported.
    input  wire rcp_pkg::rcp_meas_t meas_set,
    input  wire logic [19:0]        h0_amp,
    input  wire logic [19:0]        h5_amp,
    // Towards the stage.
    output var rcp_pkg::rcp_meas_t  meas,
    output var rcp_pkg::rcp_harm_t  harm
);
    logic [4:0] idx_r;
    // Only slots 0 and 5 carry energy, so the true RMS differs from either one alone.
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            idx_r <= 5'h00;
            meas  <= '0;
            harm  <= '0;
        end else begin
            idx_r <= idx_r + 5'h01;
            meas  <= meas_set;
            harm  <= '{valid: 1'b1, chan: 1'b0, index: idx_r,
                amp: (idx_r == 5'h00) ? h0_amp : (idx_r == 5'h05) ? h5_amp : 20'h00000};
        end
    end
endmodule : rcp_fe_model
`default_nettype wire

//--- rcp_stage_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module rcp_stage_tb_top;
    localparam int TICK = 300;
    localparam int SETTLE = 450;
    logic               sys_clk, rst_b, psel, penable, pwrite, pready, pslverr, rd_e;
    logic               block_in, force_ena, start, blocked, trip, irq;
    logic [7:0]         paddr;
    logic [31:0]        pwdata, prdata, rd_v;
    logic [2:0]         active_group;
    logic [19:0]        h0_amp, h5_amp;
    rcp_pkg::rcp_meas_t meas, meas_set;
    rcp_pkg::rcp_harm_t harm;
    int                 mismatches, n_compared;
    wire logic [31:0]   outs = {29'h0, trip, blocked, start};
    ////////////////////////////////////////////////////////////////////////////////
    rcp_stage #(.TICK_CYCLES(TICK)) DUT (.SYS_CLK(sys_clk), .RST_B(rst_b), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .MEAS(meas), .HARM(harm),
        .ACTIVE_GROUP(active_group), .BLOCK_IN(block_in), .FORCE_ENA(force_ena),
        .START(start), .BLOCKED(blocked), .TRIP(trip), .IRQ(irq));
    rcp_fe_model u_fe (.sys_clk(sys_clk), .rst_b(rst_b), .meas_set(meas_set),
        .h0_amp(h0_amp), .h5_amp(h5_amp), .meas(meas), .harm(harm));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        if (mismatches == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // One APB transfer; request held until pready is sampled high.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd_v = prdata;
        rd_e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
        if (n >= 20) begin
            mismatches++;
            end_sim();
        end
    endtask : apb
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd_v, exp);
    endtask : rdchk
    // Long enough for one tick plus the worst evaluation latency.
    task automatic step(input logic [19:0] crms, input logic [31:0] exp);
        meas_set.coarse_rms <= crms;
        repeat (SETTLE) @(posedge sys_clk);
        chk(outs, exp);
    endtask : step
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rdchk(rcp_pkg::OFS_CTRL, rcp_pkg::CTRL_RST);
        rdchk(rcp_pkg::OFS_LEVEL0, {12'h0, rcp_pkg::LEVEL_DEF});
        apb(1'b0, 8'hFC, 32'h0);
        chk({31'h0, rd_e}, 32'h1);
        chk(outs, 32'h0);
    endtask : t_reset
    task automatic t_remote();
        apb(1'b1, rcp_pkg::OFS_LEVEL0, 32'h2710);
        rdchk(rcp_pkg::OFS_LEVEL0, 32'h2EE0);
        apb(1'b1, rcp_pkg::OFS_CTRL, 32'h10);
        apb(1'b1, rcp_pkg::OFS_LEVEL0, 32'h61A81);
        rdchk(rcp_pkg::OFS_LEVEL0, 32'h2EE0);
        apb(1'b1, rcp_pkg::OFS_LEVEL0, 32'h1);
        rdchk(rcp_pkg::OFS_LEVEL0, 32'h1);
        apb(1'b1, rcp_pkg::OFS_LEVEL0, 32'h2710);
        rdchk(rcp_pkg::OFS_LEVEL0, 32'h2710);
    endtask : t_remote
    // Pick-up just above level, hold at exactly 97 percent, release one count below.
    task automatic t_pickup();
        apb(1'b1, rcp_pkg::OFS_IRQ_EN, 32'h1);
        step(20'h02711, 32'h1);
        rdchk(rcp_pkg::OFS_RATIO, 32'h64);
        chk({31'h0, irq}, 32'h1);
        rdchk(rcp_pkg::OFS_IRQ_STAT, 32'h1);
        apb(1'b1, rcp_pkg::OFS_IRQ_CLR, 32'h1);
        repeat (2) @(posedge sys_clk);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, rcp_pkg::OFS_IRQ_EN, 32'h0);
        step(20'h025E4, 32'h1);
        step(20'h025E3, 32'h0);
        chk({31'h0, irq}, 32'h0);
        rdchk(rcp_pkg::OFS_IRQ_STAT, 32'h2);
        apb(1'b1, rcp_pkg::OFS_IRQ_CLR, 32'h3);
    endtask : t_pickup
    task automatic t_block();
        step(20'h03A98, 32'h1);
        block_in <= 1'b1;
        step(20'h03A98, 32'h2);
        step(20'h01388, 32'h0);
        step(20'h03A98, 32'h2);
        block_in <= 1'b0;
        step(20'h01388, 32'h0);
    endtask : t_block
    task automatic t_group();
        apb(1'b1, 8'h24, 32'h4E20);
        step(20'h03A98, 32'h1);
        active_group <= 3'h1;
        step(20'h03A98, 32'h0);
        rdchk(rcp_pkg::OFS_CTRL, 32'h10);
        active_group <= 3'h0;
        step(20'h01388, 32'h0);
    endtask : t_group
    // Coarse RMS, TRMS, PP, sensitive RMS, PP, calculated with PP asked.
    task automatic t_source();
        logic [31:0] ctl [6] = '{32'h10, 32'h14, 32'h18, 32'h11, 32'h19, 32'h1A};
        logic [5:0]  e = 6'b101110;
        meas_set <= '{20'h01388, 20'h03A98, 20'h03A98, 20'h01388, 20'h03A98};
        h0_amp <= 20'h02328;
        h5_amp <= 20'h02EE0;
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, rcp_pkg::OFS_CTRL, ctl[i]);
            step(20'h01388, {31'h0, e[i]});
        end
        apb(1'b1, rcp_pkg::OFS_CTRL, 32'h10);
    endtask : t_source
    task automatic t_force();
        logic [31:0] fx [4] = '{32'h0, 32'h1, 32'h4, 32'h2};
        apb(1'b1, rcp_pkg::OFS_CTRL, 32'h50);
        step(20'h01388, 32'h0);
        force_ena <= 1'b1;
        for (int f = 0; f < 4; f++) begin
            apb(1'b1, rcp_pkg::OFS_CTRL, 32'h10 | (f << 5));
            step(20'h01388, fx[f]);
        end
        force_ena <= 1'b0;
    endtask : t_force
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // A hang anywhere ends the run as a failure.
    initial begin
        repeat (40000) @(posedge sys_clk);
        mismatches++;
        end_sim();
    end
    initial begin
        {rst_b, psel, penable, pwrite, block_in, force_ena} = '0;
        {paddr, pwdata, active_group, h0_amp, h5_amp} = '0;
        meas_set = '0;
        mismatches = 0;
        n_compared = 0;
        repeat (10) @(posedge sys_clk);
        rst_b <= 1'b1;
        @(posedge sys_clk);
        t_reset();
        t_remote();
        t_pickup();
        t_block();
        t_group();
        t_source();
        t_force();
        end_sim();
    end
endmodule : rcp_stage_tb_top
`default_nettype wire
